// ---- rtl/dcd_decoder.sv ----
/*
 Control-instruction decoder: decodes program words, drives the datapath
 controls, keeps the status words and the repeat counter, and exposes control
 and state on a classic Wishbone slave.
 Assumes instruction word, operand word and temporary register come from logic
 on sys_clk and are valid in the cycle that instr_valid is high.
*/
// Our own choices: the Wishbone interface to the registers and the register offsets.
`include "dcd_params.svh"
module dcd_decoder (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // register bus
   input  wire dcd_pkg::dcd_wb_req_t wb_req,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o,
   // program word and operands
   input  wire logic              instr_valid,
   input  wire logic [15:0]       instr_word,
   input  wire logic [15:0]       mem_data,
   input  wire logic [3:0]        treg_low,
   // decode result
   output logic                   ctl_valid,
   output dcd_pkg::dcd_ctl_t      ctl,
   output logic                   repeat_busy,
   output logic [15:0]            status_word_zero,
   output logic [15:0]            status_word_one
);
   import dcd_pkg::*;

   logic          old_variant;
   logic          wb_hit;
   dcd_op_t       next_op;
   logic          next_illegal;
   logic [3:0]    next_bit_sel;
   logic          tested_bit;
   logic          apply;
   logic [7:0]    rep_count;
   logic [7:0]    rep_value;
   logic          rep_load;

   // word decode
   always_comb begin
      next_op = dcd_none_op;
      if (instr_word[15:12] == `DCD_BIT_TOP) begin
         next_op = dcd_tbit_op;
      end else begin
         case (instr_word[15:8])
            `DCD_HI_TREG_PROBE: next_op = treg_flag_probe_op;
            `DCD_HI_LST0:  next_op = load_status_zero_op;
            `DCD_HI_LOAD_STATUS_ONE_OP:  next_op = load_status_one_op;
            `DCD_HI_SST0:  next_op = save_status_zero_op;
            `DCD_HI_SAVE_STATUS_ONE_OP:  next_op = save_status_one_op;
            `DCD_HI_PULL_MEM:  next_op = stack_pull_to_memory_op;
            `DCD_HI_PLACE_MEM: next_op = stack_place_from_memory_op;
            `DCD_HI_REP_MEM:   next_op = repeat_by_memory_op;
            `DCD_HI_REP_IMM:   next_op = repeat_by_immediate_op;
            default: begin
               case (instr_word)
                  `DCD_W_BLK_DATA:  next_op = block_to_data_space_op;
                  `DCD_W_BLK_PROG:  next_op = block_to_program_space_op;
                  `DCD_W_POP:       next_op = dcd_pop_acc_op;
                  `DCD_W_PUSH:      next_op = dcd_push_acc_op;
                  `DCD_W_SAT_CLR:   next_op = clear_saturation_mode_op;
                  `DCD_W_SAT_SET:   next_op = set_saturation_mode_op;
                  `DCD_W_CARRY_CLR: next_op = clear_carry_op;
                  `DCD_W_CARRY_SET: next_op = set_carry_op;
                  `DCD_W_HOLD_CLR:  next_op = clear_hold_mode_op;
                  `DCD_W_HOLD_SET:  next_op = set_hold_mode_op;
                  `DCD_W_FLAG_CLR:  next_op = dcd_clear_test_flag_op;
                  `DCD_W_FLAG_SET:  next_op = set_test_flag_op;
                  `DCD_W_RSXM: next_op = dcd_clear_sxm_op;
                  `DCD_W_SSXM: next_op = dcd_set_sxm_op;
                  `DCD_W_EINT: next_op = dcd_int_on_op;
                  `DCD_W_DINT: next_op = dcd_int_off_op;
                  `DCD_W_IDLE: next_op = dcd_idle_op;
                  `DCD_W_TRAP: next_op = dcd_trap_op;
                  `DCD_W_NOP:  next_op = dcd_nop_op;
                  default:     next_op = dcd_none_op;
               endcase
            end
         endcase
      end
   end

   // older variant lacks the carry, hold and flag set/reset words
   always_comb begin
      case (next_op)
         clear_carry_op, set_carry_op, clear_hold_mode_op, set_hold_mode_op,
         dcd_clear_test_flag_op, set_test_flag_op:
            next_illegal = old_variant;
         dcd_none_op: next_illegal = 1'b1;
         default:     next_illegal = 1'b0;
      endcase
   end

   // bit number 0 is the most significant operand bit
   assign next_bit_sel = (next_op == treg_flag_probe_op) ? treg_low : instr_word[11:8];
   assign tested_bit   = mem_data[4'hf - next_bit_sel];
   assign apply        = instr_valid && !next_illegal;

   dcd_status u_status (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .apply      (apply),
      .op         (next_op),
      .mem_data   (mem_data),
      .tested_bit (tested_bit),
      .sw0        (status_word_zero),
      .sw1        (status_word_one)
   );

   assign rep_load  = apply && (next_op == repeat_by_memory_op ||
                                next_op == repeat_by_immediate_op);
   assign rep_value = (next_op == repeat_by_immediate_op) ? instr_word[7:0] : mem_data[7:0];

   dcd_repeat #(
      .CW (8)
   ) u_repeat (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .load       (rep_load),
      .load_value (rep_value),
      .step       (instr_valid),
      .count      (rep_count),
      .busy       (repeat_busy)
   );

   // registered decode result
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctl_valid <= 1'b0;
         ctl       <= '0;
      end else begin
         ctl_valid        <= instr_valid;
         ctl.op           <= next_op;
         ctl.illegal      <= next_illegal;
         ctl.mem_ref      <= instr_word[7:0];
         ctl.bit_sel      <= next_bit_sel;
         // only a stack pop reaches the accumulator; bit tests never do
         ctl.acc_wr       <= apply && next_op == dcd_pop_acc_op;
         ctl.stack_push   <= apply && (next_op == dcd_push_acc_op ||
                                       next_op == stack_place_from_memory_op);
         ctl.stack_pop    <= apply && (next_op == dcd_pop_acc_op ||
                                       next_op == stack_pull_to_memory_op);
         ctl.mem_wr       <= apply && (next_op == save_status_zero_op ||
                                       next_op == save_status_one_op ||
                                       next_op == stack_pull_to_memory_op);
         ctl.store_word   <= (next_op == save_status_one_op) ? status_word_one
                                                             : status_word_zero;
      end
   end

   // wishbone slave, one wait state
   assign wb_hit = wb_req.cyc && wb_req.stb && !wb_ack_o;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_hit;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         old_variant <= `DCD_CTRL_RESET;
      end else if (wb_hit && wb_req.we && wb_req.sel[0] &&
                   wb_req.adr == `DCD_REG_CTRL) begin
         old_variant <= wb_req.dat[`DCD_CTRL_OLD_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_dat_o <= '0;
      end else if (wb_hit) begin
         case (wb_req.adr)
            `DCD_REG_CTRL:    wb_dat_o <= {31'h0, old_variant};
            `DCD_REG_STATUS0: wb_dat_o <= {16'h0, status_word_zero};
            `DCD_REG_STATUS1: wb_dat_o <= {16'h0, status_word_one};
            `DCD_REG_DECODE:  wb_dat_o <= {16'h0, rep_count, 2'h0, ctl.illegal, ctl.op};
            default:          wb_dat_o <= '0;
         endcase
      end
   end

   // checks
   AST_BIT_DECODE: assert property (@(posedge sys_clk) disable iff (rst)
      instr_valid && instr_word[15:12] == 4'h9
      |=> ctl.op == dcd_tbit_op && ctl.bit_sel == $past(instr_word[11:8])
          && ctl.mem_ref == $past(instr_word[7:0]))
      else $error("bit test word not decoded");

   AST_BIT_NO_ACC: assert property (@(posedge sys_clk) disable iff (rst)
      instr_valid && (instr_word[15:12] == 4'h9 || instr_word[15:8] == 8'h57)
      |=> !ctl.acc_wr && status_word_one[`DCD_S1_TC] == $past(tested_bit))
      else $error("bit test touched accumulator or missed flag");

   AST_TREG_FLAG_PROBE_OP_TREG: assert property (@(posedge sys_clk) disable iff (rst)
      instr_valid && instr_word[15:8] == 8'h57
      |=> ctl.op == treg_flag_probe_op && ctl.bit_sel == $past(treg_low))
      else $error("register bit test wrong");

   AST_CNF: assert property (@(posedge sys_clk) disable iff (rst)
      instr_valid && (instr_word == 16'hce04 || instr_word == 16'hce05)
      |=> status_word_one[`DCD_S1_CNF] == $past(instr_word[0]))
      else $error("block space not set");

   AST_LOAD_ST: assert property (@(posedge sys_clk) disable iff (rst)
      instr_valid && instr_word[15:8] == 8'h50
      |=> status_word_zero == $past(mem_data))
      else $error("status zero not loaded");

   AST_STORE_ST1: assert property (@(posedge sys_clk) disable iff (rst)
      instr_valid && instr_word[15:8] == 8'h79
      |=> ctl.mem_wr && ctl.store_word == $past(status_word_one))
      else $error("status one store wrong");

   AST_STACK: assert property (@(posedge sys_clk) disable iff (rst)
      instr_valid && instr_word == 16'hce1d
      |=> ctl.stack_pop && ctl.acc_wr && !ctl.stack_push)
      else $error("pop to accumulator wrong");

   AST_SAT_MODE: assert property (@(posedge sys_clk) disable iff (rst)
      instr_valid && instr_word == 16'hce03
      |=> status_word_zero[`DCD_S0_SAT] ##1 1'b1)
      else $error("saturation mode not set");

   AST_OLD_VARIANT: assert property (@(posedge sys_clk) disable iff (rst)
      instr_valid && old_variant && instr_word == 16'hce31
      |=> ctl.illegal && $stable(status_word_one))
      else $error("older variant executed carry set");

   AST_REP_IMM: assert property (@(posedge sys_clk) disable iff (rst)
      instr_valid && instr_word[15:8] == 8'hcb
      |=> rep_count == $past(instr_word[7:0]))
      else $error("immediate repeat count wrong");

   AST_MODE_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
      !instr_valid |=> $stable(status_word_zero) && $stable(status_word_one))
      else $error("mode bits changed without op");

   COV_BIT_SAT: cover property (@(posedge sys_clk) disable iff (rst)
      instr_valid && instr_word[15:12] == 4'h9 && instr_word[1:0] == 2'b00
      && status_word_zero[`DCD_S0_SAT]);
   COV_REP_DONE: cover property (@(posedge sys_clk) disable iff (rst)
      repeat_busy ##1 !repeat_busy);
   COV_OLD_REFUSE: cover property (@(posedge sys_clk) disable iff (rst)
      ctl_valid && ctl.illegal && old_variant);
   COV_WB_READ: cover property (@(posedge sys_clk) disable iff (rst)
      wb_ack_o && !wb_req.we);
endmodule

// ---- rtl/dcd_repeat.sv ----
/*
 Repeat counter: loaded by the repeat ops, counts the following words down.
 Assumes step pulses once per fetched instruction word.
*/
module dcd_repeat #(
   parameter int CW = 8
) (
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst,
   // control
   input  wire logic          load,
   input  wire logic [CW-1:0] load_value,
   input  wire logic          step,
   // state
   output logic [CW-1:0]      count,
   output logic               busy
);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count <= '0;
      end else if (load) begin
         count <= load_value;
      end else if (step && count != '0) begin
         count <= count - CW'(1);
      end
   end

   assign busy = (count != '0);
endmodule

// ---- rtl/dcd_status.sv ----
/*
 Status words zero and one with the mode bits that the control ops change.
 Assumes op is presented for one cycle with apply high, already screened
 for the selected variant.
*/
`include "dcd_params.svh"
module dcd_status (
   // clock and reset
   input  wire logic           sys_clk,
   input  wire logic           rst,
   // applied op
   input  wire logic           apply,
   input  wire dcd_pkg::dcd_op_t op,
   input  wire logic [15:0]    mem_data,
   input  wire logic           tested_bit,
   // status words
   output logic [15:0]         sw0,
   output logic [15:0]         sw1
);
   import dcd_pkg::*;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sw0 <= `DCD_SW0_RESET;
      end else if (apply) begin
         case (op)
            load_status_zero_op:      sw0 <= mem_data;
            clear_saturation_mode_op: sw0[`DCD_S0_SAT] <= 1'b0;
            set_saturation_mode_op:   sw0[`DCD_S0_SAT] <= 1'b1;
            dcd_int_on_op:            sw0[`DCD_S0_INTM] <= 1'b0;
            dcd_int_off_op:           sw0[`DCD_S0_INTM] <= 1'b1;
            default:                  sw0 <= sw0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sw1 <= `DCD_SW1_RESET;
      end else if (apply) begin
         case (op)
            load_status_one_op:        sw1 <= mem_data;
            block_to_data_space_op:    sw1[`DCD_S1_CNF] <= 1'b0;
            block_to_program_space_op: sw1[`DCD_S1_CNF] <= 1'b1;
            treg_flag_probe_op,
            dcd_tbit_op:               sw1[`DCD_S1_TC] <= tested_bit;
            clear_carry_op:            sw1[`DCD_S1_C] <= 1'b0;
            set_carry_op:              sw1[`DCD_S1_C] <= 1'b1;
            clear_hold_mode_op:        sw1[`DCD_S1_HM] <= 1'b0;
            set_hold_mode_op:          sw1[`DCD_S1_HM] <= 1'b1;
            dcd_clear_test_flag_op:    sw1[`DCD_S1_TC] <= 1'b0;
            set_test_flag_op:          sw1[`DCD_S1_TC] <= 1'b1;
            dcd_clear_sxm_op:          sw1[`DCD_S1_SXM] <= 1'b0;
            dcd_set_sxm_op:            sw1[`DCD_S1_SXM] <= 1'b1;
            default:                   sw1 <= sw1;
         endcase
      end
   end
endmodule

// ---- shared/dcd_params.svh ----
/*
 Offsets, opcode patterns, status bit positions, reset values and timing counts
 for the control-instruction decoder.
 Assumes inclusion by bare name from design and bench files.
*/
`ifndef DCD_PARAMS_SVH
`define DCD_PARAMS_SVH

// register byte offsets
`define DCD_REG_CTRL       8'h00
`define DCD_REG_STATUS0    8'h04
`define DCD_REG_STATUS1    8'h08
`define DCD_REG_DECODE     8'h0c
`define DCD_CTRL_OLD_BIT   0
`define DCD_CTRL_RESET     1'b0

// opcode patterns
`define DCD_BIT_TOP        4'h9
`define DCD_HI_TREG_PROBE  8'h57
`define DCD_HI_LST0        8'h50
`define DCD_HI_LOAD_STATUS_ONE_OP        8'h51
`define DCD_HI_SST0        8'h78
`define DCD_HI_SAVE_STATUS_ONE_OP        8'h79
`define DCD_HI_PULL_MEM    8'h7a
`define DCD_HI_PLACE_MEM   8'h54
`define DCD_HI_REP_MEM     8'h4b
`define DCD_HI_REP_IMM     8'hcb
`define DCD_W_EINT         16'hce00
`define DCD_W_DINT         16'hce01
`define DCD_W_SAT_CLR      16'hce02
`define DCD_W_SAT_SET      16'hce03
`define DCD_W_BLK_DATA     16'hce04
`define DCD_W_BLK_PROG     16'hce05
`define DCD_W_RSXM         16'hce06
`define DCD_W_SSXM         16'hce07
`define DCD_W_PUSH         16'hce1c
`define DCD_W_POP          16'hce1d
`define DCD_W_TRAP         16'hce1e
`define DCD_W_IDLE         16'hce1f
`define DCD_W_CARRY_CLR    16'hce30
`define DCD_W_CARRY_SET    16'hce31
`define DCD_W_FLAG_CLR     16'hce32
`define DCD_W_FLAG_SET     16'hce33
`define DCD_W_HOLD_CLR     16'hce38
`define DCD_W_HOLD_SET     16'hce39
`define DCD_W_NOP          16'h5500

// status bit positions
`define DCD_S0_SAT         0
`define DCD_S0_INTM        1
`define DCD_S1_CNF         0
`define DCD_S1_TC          1
`define DCD_S1_SXM         2
`define DCD_S1_C           3
`define DCD_S1_HM          4
`define DCD_SW0_RESET      16'h0002
`define DCD_SW1_RESET      16'h0014

// timing: decode result one cycle after the word, bus ack one cycle after request
`define DCD_DECODE_LAT     1
`define DCD_ACK_LAT        1

`endif

// ---- shared/dcd_pkg.sv ----
/*
 Types of the control-instruction decoder: op classes, decode result, bus request.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dcd_pkg;
   typedef enum logic [4:0] {
      dcd_none_op,
      treg_flag_probe_op,
      dcd_tbit_op,
      block_to_data_space_op,
      block_to_program_space_op,
      load_status_zero_op,
      load_status_one_op,
      save_status_zero_op,
      save_status_one_op,
      dcd_pop_acc_op,
      dcd_push_acc_op,
      stack_pull_to_memory_op,
      stack_place_from_memory_op,
      repeat_by_memory_op,
      repeat_by_immediate_op,
      clear_saturation_mode_op,
      set_saturation_mode_op,
      clear_carry_op,
      set_carry_op,
      clear_hold_mode_op,
      set_hold_mode_op,
      dcd_clear_test_flag_op,
      set_test_flag_op,
      dcd_clear_sxm_op,
      dcd_set_sxm_op,
      dcd_int_on_op,
      dcd_int_off_op,
      dcd_idle_op,
      dcd_trap_op,
      dcd_nop_op
   } dcd_op_t;

   typedef struct packed {
      dcd_op_t     op;
      logic [7:0]  mem_ref;
      logic [3:0]  bit_sel;
      logic        acc_wr;
      logic        stack_push;
      logic        stack_pop;
      logic        mem_wr;
      logic [15:0] store_word;
      logic        illegal;
   } dcd_ctl_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } dcd_wb_req_t;
endpackage

// ---- verif/dcd_prog_mem_model.sv ----
/*
 Program memory model: hands the decoder one word with its operand and
 temporary-register bits per call.
 Assumes calls start on a rising edge; released lines show inverted data.
*/
module dcd_prog_mem_model (
   // clock
   input  wire logic   sys_clk,
   // word to the decoder
   output logic        instr_valid,
   output logic [15:0] instr_word,
   output logic [15:0] mem_data,
   output logic [3:0]  treg_low
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      instr_valid = 1'b0;
      instr_word  = 16'h0000;
      mem_data    = 16'h0000;
      treg_low    = 4'h0;
   end
   // held until the edge that takes it
   task automatic put(input logic [15:0] w, input logic [15:0] d, input logic [3:0] t);
      instr_valid <= 1'b1;
      instr_word  <= w;
      mem_data    <= d;
      treg_low    <= t;
      @(posedge sys_clk);
   endtask
   // no stale word may look valid
   task automatic idle();
      instr_valid <= 1'b0;
      instr_word  <= ~instr_word;
      mem_data    <= ~mem_data;
      treg_low    <= ~treg_low;
   endtask
endmodule

// ---- verif/dsp_control_instr_decoder_tb_top.sv ----
/*
 Self-checking bench of the control-instruction decoder, one task a scenario.
 Assumes the package, the design and the memory model are compiled first.
*/
`include "dcd_params.svh"
module dsp_control_instr_decoder_tb_top import dcd_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk;
   logic        rst;
   dcd_wb_req_t wb_req;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        instr_valid;
   logic [15:0] instr_word;
   logic [15:0] mem_data;
   logic [3:0]  treg_low;
   logic        ctl_valid;
   dcd_ctl_t    ctl;
   logic        repeat_busy;
   logic [15:0] status_word_zero;
   logic [15:0] status_word_one;
   logic [31:0] rd;
   int          n_errors;
   int          samples_checked;

   dcd_decoder u_dut (.sys_clk, .rst, .wb_req, .wb_dat_o, .wb_ack_o, .instr_valid,
      .instr_word, .mem_data, .treg_low, .ctl_valid, .ctl, .repeat_busy,
      .status_word_zero, .status_word_one);
   dcd_prog_mem_model u_mem (.sys_clk, .instr_valid, .instr_word, .mem_data, .treg_low);

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic note(input logic ok, input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (!ok) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_bit(input logic g, input logic e);
      note(g === e, 32'(g), 32'(e));
   endtask
   task automatic cmp_w(input logic [15:0] g, input logic [15:0] e);
      note(g === e, 32'(g), 32'(e));
   endtask
   task automatic cmp_op(input dcd_op_t g, input dcd_op_t e);
      note(g === e, 32'(g), 32'(e));
   endtask

   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // classic single cycle, waits for ack under a bound
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, d};
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) n_errors++;
      rd = wb_dat_o;
      wb_req <= '0;
   endtask

   task automatic fetch(input logic [15:0] w, input logic [15:0] d = 16'h0,
                        input logic [3:0] t = 4'h0);
      @(posedge sys_clk);
      u_mem.put(w, d, t);
      u_mem.idle();
      #1;
      cmp_bit(ctl_valid, 1'b1);
   endtask

   task automatic t_reset();
      cmp_w(status_word_zero, 16'h0002);
      cmp_w(status_word_one, 16'h0014);
      cmp_bit(repeat_busy, 1'b0);
      wb(1'b0, `DCD_REG_STATUS1, 32'h0);
      cmp_w(rd[15:0], 16'h0014);
      wb(1'b1, 8'h40, 32'hffffffff);
      wb(1'b0, 8'h40, 32'h0);
      cmp_w(rd[15:0], 16'h0000);
      $display("test reset done");
   endtask

   task automatic t_sat();
      fetch(16'hce03);
      cmp_op(ctl.op, set_saturation_mode_op);
      cmp_bit(status_word_zero[0], 1'b1);
      fetch(16'h785a);
      cmp_op(ctl.op, save_status_zero_op);
      cmp_bit(ctl.mem_wr, 1'b1);
      cmp_w({8'h00, ctl.mem_ref}, 16'h005a);
      cmp_bit(ctl.store_word[0], 1'b1);
      fetch(16'hce02);
      cmp_op(ctl.op, clear_saturation_mode_op);
      cmp_bit(status_word_zero[0], 1'b0);
      $display("test saturation done");
   endtask

   task automatic t_bit();
      logic [15:0] w [3] = '{16'h9b04, 16'h9000, 16'h9f80};
      logic [15:0] d [3] = '{16'h0010, 16'h7fff, 16'h0001};
      logic        e [3] = '{1'b1, 1'b0, 1'b1};
      fetch(16'hce03);
      for (int i = 0; i < 3; i++) begin
         fetch(w[i], d[i]);
         cmp_op(ctl.op, dcd_tbit_op);
         cmp_w({12'h000, ctl.bit_sel}, {12'h000, w[i][11:8]});
         cmp_w({8'h00, ctl.mem_ref}, {8'h00, w[i][7:0]});
         cmp_bit(ctl.acc_wr, 1'b0);
         cmp_bit(status_word_one[1], e[i]);
      end
      fetch(16'hce02);
      fetch(16'h5704, 16'hdfff, 4'h2);
      cmp_op(ctl.op, treg_flag_probe_op);
      cmp_bit(status_word_one[1], 1'b0);
      cmp_bit(ctl.acc_wr, 1'b0);
      fetch(16'h5781, 16'h2000, 4'h2);
      cmp_bit(status_word_one[1], 1'b1);
      $display("test bit done");
   endtask

   task automatic t_cnf();
      fetch(16'hce05);
      cmp_op(ctl.op, block_to_program_space_op);
      cmp_bit(status_word_one[0], 1'b1);
      fetch(16'hce04);
      cmp_op(ctl.op, block_to_data_space_op);
      cmp_bit(status_word_one[0], 1'b0);
      $display("test config done");
   endtask

   task automatic t_status();
      fetch(16'h5011, 16'h1235);
      cmp_op(ctl.op, load_status_zero_op);
      cmp_w(status_word_zero, 16'h1235);
      // load then store back to back
      @(posedge sys_clk);
      u_mem.put(16'h5122, 16'h0a5a, 4'h0);
      u_mem.put(16'h7933, 16'h0000, 4'h0);
      u_mem.idle();
      #1;
      cmp_op(ctl.op, save_status_one_op);
      cmp_w(ctl.store_word, 16'h0a5a);
      cmp_w(status_word_one, 16'h0a5a);
      wb(1'b0, `DCD_REG_STATUS0, 32'h0);
      cmp_w(rd[15:0], 16'h1235);
      $display("test status done");
   endtask

   task automatic t_stack();
      logic [15:0] w [4] = '{16'hce1d, 16'hce1c, 16'h7a44, 16'h5455};
      dcd_op_t     o [4] = '{dcd_pop_acc_op, dcd_push_acc_op, stack_pull_to_memory_op,
                             stack_place_from_memory_op};
      logic [3:0]  s [4] = '{4'b1010, 4'b0100, 4'b0011, 4'b0100};
      for (int i = 0; i < 4; i++) begin
         fetch(w[i]);
         cmp_op(ctl.op, o[i]);
         cmp_w({12'h0, ctl.acc_wr, ctl.stack_push, ctl.stack_pop, ctl.mem_wr}, 16'(s[i]));
      end
      $display("test stack done");
   endtask

   task automatic t_repeat();
      fetch(16'hcb03);
      cmp_op(ctl.op, repeat_by_immediate_op);
      wb(1'b0, `DCD_REG_DECODE, 32'h0);
      cmp_w({8'h00, rd[15:8]}, 16'h0003);
      for (int i = 0; i < 3; i++) begin
         cmp_bit(repeat_busy, 1'b1);
         fetch(16'h5500);
      end
      cmp_bit(repeat_busy, 1'b0);
      fetch(16'h4b10, 16'hff02);
      cmp_op(ctl.op, repeat_by_memory_op);
      fetch(16'h5500);
      cmp_bit(repeat_busy, 1'b1);
      fetch(16'h5500);
      cmp_bit(repeat_busy, 1'b0);
      fetch(16'hcb00);
      cmp_bit(repeat_busy, 1'b0);
      $display("test repeat done");
   endtask

   task automatic t_old();
      logic [15:0] w [6] = '{16'hce31, 16'hce30, 16'hce39, 16'hce38, 16'hce33, 16'hce32};
      dcd_op_t     o [6] = '{set_carry_op, clear_carry_op, set_hold_mode_op,
                             clear_hold_mode_op, set_test_flag_op, dcd_clear_test_flag_op};
      int          b [6] = '{3, 3, 4, 4, 1, 1};
      logic [15:0] keep;
      wb(1'b1, `DCD_REG_CTRL, 32'h1);
      wb(1'b0, `DCD_REG_CTRL, 32'h0);
      cmp_bit(rd[0], 1'b1);
      keep = status_word_one;
      for (int i = 0; i < 6; i++) begin
         fetch(w[i]);
         cmp_bit(ctl.illegal, 1'b1);
         cmp_w(status_word_one, keep);
      end
      fetch(16'hce07);
      cmp_bit(ctl.illegal, 1'b0);
      fetch(16'hce1a);
      cmp_w({12'h0, ctl.illegal, ctl.acc_wr, ctl.stack_push, ctl.mem_wr}, 16'h0008);
      wb(1'b1, `DCD_REG_CTRL, 32'h0);
      for (int i = 0; i < 6; i++) begin
         fetch(w[i]);
         cmp_op(ctl.op, o[i]);
         cmp_bit(status_word_one[b[i]], !i[0]);
      end
      $display("test variant done");
   endtask

   initial begin
      n_errors = 0;
      samples_checked = 0;
      wb_req = '0;
      rst = 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_sat();
      t_bit();
      t_cnf();
      t_status();
      t_stack();
      t_repeat();
      t_old();
      finish_test();
   end

   // the tests need about a hundred cycles; 5000 cycles means a hang
   initial begin
      #20000;
      n_errors++;
      finish_test();
   end
endmodule
